//--- dv/test_mcx_core.sv
// Self-checking bench for the instruction execute block, with a reference model.
// Assumes the package opcodes and the hand-over timing: results one cycle after the take.
`timescale 1ns/1ps
module test_mcx_core;
    import mcx_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    mcx_op_t i_op = OP_NOP;
    logic [DATA_W-1:0] i_imm = 8'h00;
    logic [PC_W-1:0] i_target = 13'h0000;
    logic [DATA_W-1:0] i_mem_rdata = 8'h00;
    logic [PC_W-1:0] i_stack_top = 13'h0000;
    logic i_irq_pending = 1'b0;
    logic i_wake = 1'b0;
    logic o_ready, o_mem_we, o_pop, o_clk_gate, o_wdt_clear, o_irq_take;
    logic o_power_down_flag, o_watchdog_timeout_flag, o_global_interrupt_enable;
    logic [DATA_W-1:0] o_mem_wdata, o_accumulator;
    logic [PC_W-1:0] o_pc;
    logic [FLG_W-1:0] o_flags;
    logic [DATA_W-1:0] acc_m = ACC_RST;
    logic [PC_W-1:0] pc_m = PC_RST;
    logic [FLG_W-1:0] fl_m = FLG_RST;
    logic gie_m = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    mcx_op_t op;
    ////////////////////////////////////////////////////////////////////////////////
    mcx_core mcx_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op),
        .i_imm(i_imm), .i_target(i_target), .i_mem_rdata(i_mem_rdata),
        .i_stack_top(i_stack_top), .i_irq_pending(i_irq_pending), .i_wake(i_wake),
        .o_ready(o_ready), .o_mem_addr_unused(), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
        .o_pop(o_pop), .o_clk_gate(o_clk_gate), .o_wdt_clear(o_wdt_clear),
        .o_irq_take(o_irq_take), .o_accumulator(o_accumulator), .o_pc(o_pc), .o_flags(o_flags),
        .o_power_down_flag(o_power_down_flag), .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
        .o_global_interrupt_enable(o_global_interrupt_enable));
    // The 200 MHz clock, and a cycle ceiling well above the planned run of about 500 cycles.
    always #2.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and stops the run.
    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Case equality, so an unknown on the design side never passes.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Issues one instruction at a falling edge and compares with the model one cycle later.
    // During a dummy cycle a junk request is held up, which the block must refuse.
    task automatic run_op(input mcx_op_t op, input logic [7:0] m, imm, input logic [12:0] tg,
            stk, input logic pend);
        int d, n;
        logic [7:0] r, b, wd;
        logic we, pp, lg;
        logic [12:0] npc;
        we = 0; wd = 0; pp = 0; lg = 0; r = acc_m; npc = pc_m + PC_ONE;
        case (op)
            OP_INC, OP_INCA: begin
                r = m + BYTE_ONE;
                fl_m[FLG_Z] = (r == 8'h00);
                we = (op == OP_INC);
            end
            OP_JMP: begin npc = tg; lg = 1; end
            OP_MOV_AM: r = m;
            OP_MOV_AX: r = imm;
            OP_MOV_MA: we = 1;
            OP_OR_AM, OP_OR_AX, OP_ORM: begin
                r = acc_m | ((op == OP_OR_AX) ? imm : m);
                fl_m[FLG_Z] = (r == 8'h00);
                we = (op == OP_ORM);
            end
            OP_RET, OP_INTERRUPT_RETURN: begin npc = stk; pp = 1; lg = 1; end
            OP_RET_AX: begin r = imm; npc = stk; pp = 1; lg = 1; end
            OP_RL, OP_RLA: begin r = {m[6:0], m[7]}; we = (op == OP_RL); end
            OP_RR, OP_RRA: begin r = {m[0], m[7:1]}; we = (op == OP_RR); end
            OP_RLC, OP_RLCA: begin
                r = {m[6:0], fl_m[FLG_C]};
                fl_m[FLG_C] = m[7];
                we = (op == OP_RLC);
            end
            OP_RRC, OP_RRCA: begin
                r = {fl_m[FLG_C], m[7:1]};
                fl_m[FLG_C] = m[0];
                we = (op == OP_RRC);
            end
            OP_SBC_AM, OP_SBC_AX, OP_SBCM: begin
                b = (op == OP_SBC_AX) ? imm : m;
                d = int'(acc_m) - int'(b) - (1 - int'(fl_m[FLG_C]));
                n = int'(acc_m[3:0]) - int'(b[3:0]) - (1 - int'(fl_m[FLG_C]));
                r = d[7:0];
                fl_m[FLG_OV] = (acc_m[7] ^ b[7]) & (acc_m[7] ^ r[7]);
                fl_m[FLG_Z] = (r == 8'h00);
                fl_m[FLG_SZ] = (r == 8'h00);
                fl_m[FLG_CZ] = (r == 8'h00) && fl_m[FLG_CZ];
                fl_m[FLG_AC] = (n >= 0);
                fl_m[FLG_C] = (d >= 0);
                we = (op == OP_SBCM);
            end
            OP_SDZ, OP_SDZA: begin
                r = m - BYTE_ONE;
                we = (op == OP_SDZ);
                lg = (r == BYTE_ZERO);
                if (lg) npc = pc_m + 13'h0002;
            end
            default: ;
        endcase
        if (we) begin
            wd = (op == OP_MOV_MA) ? acc_m : r;
            r = acc_m;
        end
        if (op == OP_INTERRUPT_RETURN) gie_m = 1;
        i_valid = 1; i_op = op; i_imm = imm; i_mem_rdata = m; i_target = tg;
        i_stack_top = stk; i_irq_pending = pend;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        // Only a dummy cycle gets a junk request; otherwise the next call drives the inputs,
        // so no input is assigned twice in one time step.
        if (lg) begin
            i_op = OP_MOV_AX;
            i_imm = ~r;
            i_irq_pending = 0;
        end
        acc_m = r;
        chk("acc", acc_m, o_accumulator);
        chk("flags", fl_m, o_flags);
        chk("mem_we", we, o_mem_we);
        if (we) chk("mem_wdata", wd, o_mem_wdata);
        chk("pop", pp, o_pop);
        chk("ready", !lg, o_ready);
        chk("irq_take", pend && op == OP_INTERRUPT_RETURN, o_irq_take);
        chk("int_enable", gie_m, o_global_interrupt_enable);
        chk("pc", npc, o_pc);
        pc_m = npc;
        if (lg) begin
            repeat (LONG_CYCLES - 1) @(negedge i_sys_clk);
            chk("refused_acc", acc_m, o_accumulator);
            chk("ready_back", 1'b1, o_ready);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset, random traffic over every opcode except halt, then power-down and a pending interrupt return.
    initial begin
        void'($urandom(78));
        repeat (2) @(negedge i_sys_clk);
        i_rst = 0;
        chk("rst_acc", ACC_RST, o_accumulator);
        chk("rst_pc", PC_RST, o_pc);
        chk("rst_flags", FLG_RST, o_flags);
        chk("rst_ready", 1'b1, o_ready);
        for (int k = 0; k < 27; k++) run_op(mcx_op_t'(k == 1 ? 0 : k), 8'h01, 8'h80, 13'h0155,
            13'h0A0A, 1'b0);
        for (int k = 0; k < 400; k++) begin
            op = mcx_op_t'($urandom_range(0, 26));
            if (op == OP_HALT) op = OP_NOP;
            run_op(op, ($urandom % 4 == 0) ? 8'h01 : 8'($urandom), 8'($urandom),
                13'($urandom), 13'($urandom), 1'b0);
        end
        i_valid = 1; i_op = OP_HALT;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_op = OP_MOV_AX; i_imm = ~acc_m;
        chk("pdf", 1'b1, o_power_down_flag);
        chk("timeout_flag", 1'b0, o_watchdog_timeout_flag);
        chk("clk_gate", 1'b1, o_clk_gate);
        chk("wdt_clear", 1'b1, o_wdt_clear);
        chk("halt_ready", 1'b0, o_ready);
        repeat (3) @(negedge i_sys_clk);
        i_valid = 0;
        chk("halt_acc", acc_m, o_accumulator);
        chk("halt_flags", fl_m, o_flags);
        chk("wdt_pulse", 1'b0, o_wdt_clear);
        i_wake = 1;
        for (int w = 0; w < 8 && o_ready !== 1'b1; w++) @(negedge i_sys_clk);
        i_wake = 0;
        pc_m = pc_m + PC_ONE;
        chk("wake_pc", pc_m, o_pc);
        chk("wake_gate", 1'b0, o_clk_gate);
        chk("wake_pdf", 1'b1, o_power_down_flag);
        run_op(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 13'h0000, 13'h0123, 1'b1);
        finish_test();
    end
endmodule // test_mcx_core

//--- hw/mcx_core.sv
// Execute stage for one stretch of an 8-bit core's instruction set.
// Assumes one decoded instruction per cycle on i_valid, a memory byte presented
// combinationally on i_mem_rdata (o_mem_addr_unused is tied to zero), and a stack that pops when o_pop pulses.
//
// Behaviour
// - Power-down halts execution, gates clock, keeps state, clears watchdog, sets power-down flag, clears timeout flag.
// - Increment adds one to memory byte; result to memory or accumulator; zero flag.
// - Jump loads target into program counter, takes two cycles, no flags.
// - Moves copy memory, immediate or accumulator as encoded; no flags change.
// - No-op changes nothing and advances to the next instruction.
// - OR combines accumulator with memory or immediate; only zero flag updates.
// - Return pops program counter; value form also loads accumulator; no flags.
// - Interrupt return pops program counter, sets global enable; pending interrupt runs first.
// - Rotate left wraps bit 7 into bit 0, no flags, accumulator form keeps memory.
// - Rotate left through carry: bit 7 to carry, old carry to bit 0.
// - Rotate right wraps bit 0 into bit 7, no flags, accumulator form keeps memory.
// - Rotate right through carry: bit 0 to carry, old carry to bit 7.
// - Subtract with borrow from memory into accumulator, six flags updated.
// - Carry clears on negative result, sets on zero or positive.
// - Immediate subtract with borrow behaves as the memory form.
// - Memory-destination subtract with borrow stores difference into memory.
// - Decrement-and-skip writes memory, skips next on zero with dummy cycle.
// - Accumulator decrement-and-skip writes accumulator, keeps memory, skips on zero.
`timescale 1ns/1ps
module mcx_core
    import mcx_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire mcx_op_t i_op,
    input wire logic [DATA_W-1:0] i_imm,
    input wire logic [PC_W-1:0] i_target,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic [PC_W-1:0] i_stack_top,
    input wire logic i_irq_pending,
    input wire logic i_wake,
    output logic o_ready,
    output logic [DATA_W-1:0] o_mem_addr_unused,
    output logic o_mem_we,
    output logic [DATA_W-1:0] o_mem_wdata,
    output logic o_pop,
    output logic o_clk_gate,
    output logic o_wdt_clear,
    output logic o_irq_take,
    output logic [DATA_W-1:0] o_accumulator,
    output logic [PC_W-1:0] o_pc,
    output logic [FLG_W-1:0] o_flags,
    output logic o_power_down_flag,
    output logic o_watchdog_timeout_flag,
    output logic o_global_interrupt_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // All state in one struct.
    typedef struct packed {
        mcx_state_t st;
        logic [DATA_W-1:0] acc;
        logic [PC_W-1:0] pc;
        logic [FLG_W-1:0] flg;
        logic power_down_flag;
        logic tof;
        logic gie;
        logic mem_we;
        logic [DATA_W-1:0] mem_wdata;
        logic pop;
        logic wdt_clr;
        logic irq_take;
    } mcx_reg_t;

    mcx_reg_t s_r;
    mcx_reg_t s_nxt;

    // Arithmetic helpers, sized so nothing is silently cut.
    logic [DATA_W:0] sub_full;
    logic [4:0] sub_low;
    logic [DATA_W-1:0] sub_opnd;
    logic [DATA_W-1:0] sub_res;
    logic [DATA_W-1:0] inc_res;
    logic [DATA_W-1:0] dec_res;
    logic borrow_in;
    logic take;

    assign take = i_valid && (s_r.st == ST_RUN);
    assign borrow_in = ~s_r.flg[FLG_C];
    assign sub_opnd = (i_op == OP_SBC_AX) ? i_imm : i_mem_rdata;
    // Nine-bit difference: its top bit is the borrow out.
    assign sub_full = {1'b0, s_r.acc} - {1'b0, sub_opnd} - {8'h00, borrow_in};
    assign sub_low = {1'b0, s_r.acc[3:0]} - {1'b0, sub_opnd[3:0]} - {4'h0, borrow_in};
    assign sub_res = sub_full[DATA_W-1:0];
    assign inc_res = i_mem_rdata + BYTE_ONE;
    assign dec_res = i_mem_rdata - BYTE_ONE;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for every opcode.
    always_comb begin
        s_nxt = s_r;
        s_nxt.mem_we = 1'b0;
        s_nxt.pop = 1'b0;
        s_nxt.wdt_clr = 1'b0;
        s_nxt.irq_take = 1'b0;
        case (s_r.st)
            ST_DUMMY: begin
                // The dummy cycle only lets the new fetch address settle.
                s_nxt.st = ST_RUN;
            end
            ST_HALTED: begin
                // Registers hold; only a wake event restarts the core.
                if (i_wake) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (take) begin
                    s_nxt.pc = s_r.pc + PC_ONE;
                    case (i_op)
                        OP_NOP: begin
                        end
                        OP_HALT: begin
                            s_nxt.st = ST_HALTED;
                            s_nxt.power_down_flag = 1'b1;
                            s_nxt.tof = 1'b0;
                            s_nxt.wdt_clr = 1'b1;
                        end
                        OP_INC, OP_INCA: begin
                            s_nxt.flg[FLG_Z] = (inc_res == BYTE_ZERO);
                            if (i_op == OP_INC) begin
                                s_nxt.mem_we = 1'b1;
                                s_nxt.mem_wdata = inc_res;
                            end else begin
                                s_nxt.acc = inc_res;
                            end
                        end
                        OP_JMP: begin
                            s_nxt.pc = i_target;
                            s_nxt.st = ST_DUMMY;
                        end
                        OP_MOV_AM: s_nxt.acc = i_mem_rdata;
                        OP_MOV_AX: s_nxt.acc = i_imm;
                        OP_MOV_MA: begin
                            s_nxt.mem_we = 1'b1;
                            s_nxt.mem_wdata = s_r.acc;
                        end
                        OP_OR_AM: begin
                            s_nxt.acc = s_r.acc | i_mem_rdata;
                            s_nxt.flg[FLG_Z] = ((s_r.acc | i_mem_rdata) == BYTE_ZERO);
                        end
                        OP_OR_AX: begin
                            s_nxt.acc = s_r.acc | i_imm;
                            s_nxt.flg[FLG_Z] = ((s_r.acc | i_imm) == BYTE_ZERO);
                        end
                        OP_ORM: begin
                            s_nxt.mem_we = 1'b1;
                            s_nxt.mem_wdata = s_r.acc | i_mem_rdata;
                            s_nxt.flg[FLG_Z] = ((s_r.acc | i_mem_rdata) == BYTE_ZERO);
                        end
                        OP_RET, OP_RET_AX: begin
                            s_nxt.pc = i_stack_top;
                            s_nxt.pop = 1'b1;
                            s_nxt.st = ST_DUMMY;
                            if (i_op == OP_RET_AX) begin
                                s_nxt.acc = i_imm;
                            end
                        end
                        OP_INTERRUPT_RETURN: begin
                            s_nxt.pc = i_stack_top;
                            s_nxt.pop = 1'b1;
                            s_nxt.gie = 1'b1;
                            s_nxt.st = ST_DUMMY;
                            // A waiting interrupt is flagged so the controller
                            // vectors before the restored address executes.
                            s_nxt.irq_take = i_irq_pending;
                        end
                        OP_RL: begin
                            s_nxt.mem_we = 1'b1;
                            s_nxt.mem_wdata = {i_mem_rdata[6:0], i_mem_rdata[7]};
                        end
                        OP_RLA: s_nxt.acc = {i_mem_rdata[6:0], i_mem_rdata[7]};
                        OP_RLC, OP_RLCA: begin
                            s_nxt.flg[FLG_C] = i_mem_rdata[7];
                            if (i_op == OP_RLC) begin
                                s_nxt.mem_we = 1'b1;
                                s_nxt.mem_wdata = {i_mem_rdata[6:0], s_r.flg[FLG_C]};
                            end else begin
                                s_nxt.acc = {i_mem_rdata[6:0], s_r.flg[FLG_C]};
                            end
                        end
                        OP_RR: begin
                            s_nxt.mem_we = 1'b1;
                            s_nxt.mem_wdata = {i_mem_rdata[0], i_mem_rdata[7:1]};
                        end
                        OP_RRA: s_nxt.acc = {i_mem_rdata[0], i_mem_rdata[7:1]};
                        OP_RRC, OP_RRCA: begin
                            s_nxt.flg[FLG_C] = i_mem_rdata[0];
                            if (i_op == OP_RRC) begin
                                s_nxt.mem_we = 1'b1;
                                s_nxt.mem_wdata = {s_r.flg[FLG_C], i_mem_rdata[7:1]};
                            end else begin
                                s_nxt.acc = {s_r.flg[FLG_C], i_mem_rdata[7:1]};
                            end
                        end
                        OP_SBC_AM, OP_SBC_AX, OP_SBCM: begin
                            // Carry acts as an inverted borrow.
                            s_nxt.flg[FLG_C] = ~sub_full[DATA_W];
                            s_nxt.flg[FLG_AC] = ~sub_low[4];
                            s_nxt.flg[FLG_Z] = (sub_res == BYTE_ZERO);
                            s_nxt.flg[FLG_OV] = (s_r.acc[7] != sub_opnd[7]) &&
                                                (sub_res[7] != s_r.acc[7]);
                            s_nxt.flg[FLG_SZ] = (sub_res == BYTE_ZERO);
                            // Chain-zero: zero only while earlier bytes were zero too.
                            s_nxt.flg[FLG_CZ] = (sub_res == BYTE_ZERO) && s_r.flg[FLG_CZ];
                            if (i_op == OP_SBCM) begin
                                s_nxt.mem_we = 1'b1;
                                s_nxt.mem_wdata = sub_res;
                            end else begin
                                s_nxt.acc = sub_res;
                            end
                        end
                        OP_SDZ, OP_SDZA: begin
                            if (i_op == OP_SDZ) begin
                                s_nxt.mem_we = 1'b1;
                                s_nxt.mem_wdata = dec_res;
                            end else begin
                                s_nxt.acc = dec_res;
                            end
                            if (dec_res == BYTE_ZERO) begin
                                s_nxt.pc = s_r.pc + PC_ONE + PC_ONE;
                                s_nxt.st = ST_DUMMY;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_r <= '{st: ST_RUN, acc: ACC_RST, pc: PC_RST, flg: FLG_RST, power_down_flag: 1'b0,
                     tof: 1'b0, gie: 1'b0, mem_we: 1'b0, mem_wdata: BYTE_ZERO,
                     pop: 1'b0, wdt_clr: 1'b0, irq_take: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; the clock gate follows the halted state directly.
    assign o_ready = (s_r.st == ST_RUN);
    assign o_mem_addr_unused = BYTE_ZERO;
    assign o_mem_we = s_r.mem_we;
    assign o_mem_wdata = s_r.mem_wdata;
    assign o_pop = s_r.pop;
    assign o_clk_gate = (s_r.st == ST_HALTED);
    assign o_wdt_clear = s_r.wdt_clr;
    assign o_irq_take = s_r.irq_take;
    assign o_accumulator = s_r.acc;
    assign o_pc = s_r.pc;
    assign o_flags = s_r.flg;
    assign o_power_down_flag = s_r.power_down_flag;
    assign o_watchdog_timeout_flag = s_r.tof;
    assign o_global_interrupt_enable = s_r.gie;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence jmp_issue;
        take && (i_op == OP_JMP);
    endsequence

    a_jump_two_cycle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        jmp_issue |=> !o_ready ##1 o_ready)
        else $error("jump did not take two cycles");
    a_jump_target: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        jmp_issue |=> (o_pc == $past(i_target)) && $stable(o_flags))
        else $error("jump target or flags wrong");
    a_halt_flags: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_HALT) |=> o_power_down_flag && !o_watchdog_timeout_flag
            && o_clk_gate && o_wdt_clear)
        else $error("power down effects missing");
    a_halt_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_clk_gate && !i_wake |=> $stable(o_accumulator) && $stable(o_pc))
        else $error("state changed while halted");
    a_nop_still: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_NOP) |=> $stable(o_accumulator) && $stable(o_flags)
            && !o_mem_we && (o_pc == $past(o_pc) + PC_ONE))
        else $error("nop changed state");
    a_mov_flags: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_MOV_AX) |=> (o_accumulator == $past(i_imm)) && $stable(o_flags))
        else $error("move immediate wrong");
    a_interrupt_return_gie: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_INTERRUPT_RETURN) |=> o_global_interrupt_enable && o_pop
            && (o_pc == $past(i_stack_top)) && (o_irq_take == $past(i_irq_pending)))
        else $error("interrupt return wrong");
    a_sbc_carry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_SBC_AX) |=> o_flags[FLG_C] == ({1'b0, $past(o_accumulator)} >=
            ({1'b0, $past(i_imm)} + {8'h00, !$past(o_flags[FLG_C])})))
        else $error("borrow carry wrong");
    a_sdz_skip: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_SDZ) && (i_mem_rdata == BYTE_ONE) |=> o_mem_we
            && (o_mem_wdata == BYTE_ZERO) && !o_ready ##1 o_ready)
        else $error("decrement skip wrong");
    a_sdza_mem: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_SDZA) |=> !o_mem_we
            && (o_accumulator == $past(i_mem_rdata) - BYTE_ONE))
        else $error("accumulator decrement wrong");
    a_rl_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && (i_op == OP_RLA) |=> (o_accumulator[0] == $past(i_mem_rdata[7])) && !o_mem_we
            && $stable(o_flags))
        else $error("rotate left wrong");
endmodule // mcx_core

//--- hw/mcx_pkg.sv
// Package for the instruction execute block: opcodes, flag positions, reset values.
// Assumes an external decoder maps real instruction words onto these opcodes.
package mcx_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    // Flag positions inside the status byte.
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SZ = 4;
    localparam int FLG_CZ = 5;
    localparam int FLG_W = 6;
    localparam logic [FLG_W-1:0] FLG_RST = 6'h00;
    // Cycles taken by a jump and by a taken skip.
    localparam int LONG_CYCLES = 2;
    typedef enum logic [4:0] {
        OP_NOP, OP_HALT, OP_INC, OP_INCA, OP_JMP, OP_MOV_AM, OP_MOV_AX, OP_MOV_MA,
        OP_OR_AM, OP_OR_AX, OP_ORM, OP_RET, OP_RET_AX, OP_INTERRUPT_RETURN, OP_RL, OP_RLA,
        OP_RLC, OP_RLCA, OP_RR, OP_RRA, OP_RRC, OP_RRCA, OP_SBC_AM, OP_SBC_AX,
        OP_SBCM, OP_SDZ, OP_SDZA
    } mcx_op_t;
    typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_HALTED} mcx_state_t;
endpackage
